//--- dv/div_driver.sv
// Fabric controller model that issues divide requests
// Assumes the bench requests on the divider clock; operands valid only with start
`timescale 1ns/1ps
`default_nettype none

module div_driver
(
	// Clock
	input  wire logic                    i_mclk,
	// Bench request
	input  wire logic                    i_go,
	input  wire logic                    i_sel,
	input  wire divider_pkg::operands_t  i_req,
	// Divider request
	output logic                         o_start,
	output logic                         o_mode,
	output divider_pkg::operands_t       o_ops
);
	// Idle request lines at time zero
	initial
	begin
		o_start = 1'b0;
		o_mode  = 1'b0;
		o_ops   = '0;
	end

	// One-cycle start, only for a legal operand pair; operands scrambled while i_go is low
	always @(posedge i_mclk)
	begin
		o_start <= i_go && (i_req.divisor != 8'h00) && (i_req.dividend > i_req.divisor);
		o_mode  <= i_sel;
		o_ops   <= i_go ? i_req : ~o_ops; // Magnitudes only, sign fixing upstream
	end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the iterative divider
// Assumes divider_pkg is compiled first and divider_defs.svh is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "divider_defs.svh"

module testbench;
	logic                    mclk;
	logic                    rst;
	logic                    ce;
	logic                    go;
	logic                    sel;
	divider_pkg::operands_t  req;
	logic                    start;
	logic                    mode;
	divider_pkg::operands_t  ops;
	logic                    busy;
	logic                    done;
	divider_pkg::result_t    result;
	int                      errors;
	int                      compares;
	int                      cycles;

	// ----------------
	// Harness
	// ----------------
	div_driver ctl_u (.i_mclk(mclk), .i_go(go), .i_sel(sel), .i_req(req), .o_start(start), .o_mode(mode), .o_ops(ops));
	iterative_divider dut_u (.i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_start(start), .i_mode(mode), .i_ops(ops),
		.o_busy(busy), .o_done(done), .o_result(result));

	// Clock at 4 ns period
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Cycle ceiling against hangs
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			errors++;
			end_of_test();
		end
	end

	// ----------------
	// Tasks
	// ----------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask

	// One division; optional clock-enable stall or a start injected while busy
	task automatic run(input string what, input logic m, input logic [7:0] n, input logic [7:0] d,
		input int stall, input int inj);
		int c;
		c = 0;
		@(posedge mclk);
		go  <= 1'b1;
		sel <= m;
		req <= {n, d};
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		ce <= (stall == 0);
		#1;
		check({what, " busy"}, 16'(busy), 16'h0001);
		while (done !== 1'b1 && c < 40)
		begin
			@(posedge mclk);
			c++;
			go <= (c == inj);
			if (c == inj)
				req <= 16'hff01;
			if (c == stall)
				ce <= 1'b1;
			#1;
		end
		check({what, " cycles"}, 16'(c), 16'(8 + stall));
		check({what, " idle"}, 16'(busy), 16'h0000);
		check({what, " quotient"}, 16'(result.quotient), 16'(n / d));
		check({what, " remainder"}, 16'(result.remainder), 16'(n % d));
		@(posedge mclk);
		#1;
		check({what, " done drop"}, 16'(done), 16'h0000);
		$display("test %s finished", what);
	endtask

	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		rst      = 1'b1;
		ce       = 1'b1;
		go       = 1'b0;
		sel      = 1'b0;
		req      = '0;
		errors   = 0;
		compares = 0;
		cycles   = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check("reset busy", 16'(busy), 16'h0000);
		check("reset done", 16'(done), 16'h0000);
		check("reset result", result, 16'h0000);
		run("sub plain", `DIV_MODE_SUB, 8'hc8, 8'h07, 0, 0);
		run("mul plain", `DIV_MODE_MUL, 8'hc8, 8'h07, 0, 0);
		run("sub wide", `DIV_MODE_SUB, 8'hff, 8'hfe, 0, 0);
		run("sub exact", `DIV_MODE_SUB, 8'h90, 8'h0c, 0, 0);
		run("mul exact", `DIV_MODE_MUL, 8'h90, 8'h0c, 0, 0);
		run("mul one", `DIV_MODE_MUL, 8'h02, 8'h01, 0, 0);
		run("mul stall", `DIV_MODE_MUL, 8'h64, 8'h03, 3, 0);
		run("sub refused", `DIV_MODE_SUB, 8'h55, 8'h05, 0, 3);
		end_of_test();
	end
endmodule
`default_nettype wire

//--- include/divider_defs.svh
// Constants for the iterative binary divider
// Assumes inclusion by bare name from design files
`ifndef DIVIDER_DEFS_SVH
`define DIVIDER_DEFS_SVH

`define DIV_WIDTH      8
`define DIV_ITERS      4'h8
`define DIV_CNT_W      4
`define DIV_ZERO_BYTE  8'h00
`define DIV_MODE_SUB   1'b0
`define DIV_MODE_MUL   1'b1

`endif

//--- include/divider_pkg.sv
// Types shared by the divider files
// Assumes divider_defs.svh is available on the include path
`include "divider_defs.svh"

package divider_pkg;

	// Operand pair handed in at start
	typedef struct packed {
		logic [`DIV_WIDTH-1:0] dividend;
		logic [`DIV_WIDTH-1:0] divisor;
	} operands_t;

	// Result pair handed out at done
	typedef struct packed {
		logic [`DIV_WIDTH-1:0] quotient;
		logic [`DIV_WIDTH-1:0] remainder;
	} result_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b10
	} div_state_t;

endpackage

//--- rtl/iterative_divider.sv
// Iterative 8-bit unsigned divider, restoring or multiply-and-subtract
// Assumes controlling fabric logic on the same clock drives start and operands
// Function
// - Takes 8-bit dividend and divisor, gives quotient and remainder.
// - Subtraction mode clears the partial remainder before the first iteration.
// - Each subtraction step shifts remainder left, filling dividend bit 8-n.
// - Subtract divisor; non-negative sets quotient bit and keeps difference.
// - Eight subtraction iterations; then quotient and remainder registers hold results.
// - Multiplication step sets trial bit 8-n, lower bits zero, upper kept.
// - Dividend minus divisor times trial; negative clears the trial bit.
// - Dividend on C, divisor on B, whole trial quotient on A.
// - After eighth multiplication step, output holds dividend minus divisor times quotient.
// - Either mode finishes in eight cycles with the combinational slice.
`timescale 1ns/1ps
`default_nettype none
`include "divider_defs.svh"

module iterative_divider
(
	// Clock, reset, enable
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst,
	input  wire logic                      i_ce,
	// Request
	input  wire logic                      i_start,
	input  wire logic                      i_mode,
	input  wire divider_pkg::operands_t    i_ops,
	// Answer
	output logic                           o_busy,
	output logic                           o_done,
	output divider_pkg::result_t           o_result
);

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------

	divider_pkg::div_state_t     state_q, state_d;
	logic [`DIV_CNT_W-1:0]       iter_q, iter_d;
	logic                        mode_q, mode_d;
	logic [`DIV_WIDTH-1:0]       num_q, num_d;
	logic [`DIV_WIDTH-1:0]       den_q, den_d;
	logic [`DIV_WIDTH-1:0]       quo_q, quo_d;
	logic [`DIV_WIDTH-1:0]       rem_q, rem_d;
	divider_pkg::result_t        res_q, res_d;

	//------------------------------------------------------------------
	// Datapath
	//------------------------------------------------------------------

	logic [`DIV_CNT_W-1:0]       bit_idx;
	logic [`DIV_WIDTH-1:0]       trial_bit;
	logic [`DIV_WIDTH-1:0]       keep_mask;
	logic [`DIV_WIDTH-1:0]       trial_q;
	logic [`DIV_WIDTH:0]         shifted;
	logic [`DIV_WIDTH:0]         sub_diff;
	logic                        sub_neg;
	logic [2*`DIV_WIDTH:0]       mul_p;
	logic                        mul_neg;

	// Bit position 8-n for iteration n = iter_q+1
	assign bit_idx = `DIV_CNT_W'(`DIV_WIDTH - 1) - iter_q;

	// One-hot trial bit and mask of bits already decided, one per bit
	genvar gi;
	generate
		for (gi = 0; gi < `DIV_WIDTH; gi = gi + 1)
		begin : g_bits
			assign trial_bit[gi] = (bit_idx == `DIV_CNT_W'(gi));
			assign keep_mask[gi] = (bit_idx < `DIV_CNT_W'(gi));
		end
	endgenerate

	// Trial quotient: decided bits kept, trial one, lower zero
	assign trial_q = (quo_q & keep_mask) | trial_bit;

	// Shift in dividend bit 8-n, then subtract divisor
	always_comb
	begin
		shifted  = {rem_q, num_q[bit_idx[2:0]]};
		sub_diff = shifted - {1'b0, den_q};
		sub_neg  = sub_diff[`DIV_WIDTH];
	end

	// Multiply-add slice: C dividend, B divisor, A trial quotient
	mul_add_slice u_slice
	(
		.i_a   (trial_q),
		.i_b   (den_q),
		.i_c   (num_q),
		.o_p   (mul_p),
		.o_neg (mul_neg)
	);

	//------------------------------------------------------------------
	// Sequencer next state
	//------------------------------------------------------------------

	// Next values for control and datapath registers
	always_comb
	begin
		state_d = state_q;
		iter_d  = iter_q;
		mode_d  = mode_q;
		num_d   = num_q;
		den_d   = den_q;
		quo_d   = quo_q;
		rem_d   = rem_q;
		res_d   = res_q;
		unique case (state_q)
			divider_pkg::ST_IDLE,
			divider_pkg::ST_DONE:
			begin
				state_d = divider_pkg::ST_IDLE;
				if (i_start)
				begin
					state_d = divider_pkg::ST_RUN;
					iter_d  = '0;
					mode_d  = i_mode;
					num_d   = i_ops.dividend;
					den_d   = i_ops.divisor;
					quo_d   = `DIV_ZERO_BYTE;
					rem_d   = (i_mode == `DIV_MODE_MUL) ? i_ops.dividend : `DIV_ZERO_BYTE;
				end
			end
			divider_pkg::ST_RUN:
			begin
				if (mode_q == `DIV_MODE_SUB)
				begin
					// Zero difference is treated as non-negative
					if (!sub_neg)
					begin
						quo_d = quo_q | trial_bit;
						rem_d = sub_diff[`DIV_WIDTH-1:0];
					end
					else
					begin
						rem_d = shifted[`DIV_WIDTH-1:0];
					end
				end
				else
				begin
					// Keep trial bit unless the slice went negative
					quo_d = mul_neg ? (quo_q & keep_mask) : trial_q;
					// Remainder tracks the slice output of the accepted trial
					if (!mul_neg)
						rem_d = mul_p[`DIV_WIDTH-1:0];
				end
				iter_d = iter_q + `DIV_CNT_W'(1);
				if (iter_q == `DIV_ITERS - `DIV_CNT_W'(1))
				begin
					state_d = divider_pkg::ST_DONE;
				end
			end
			default:
			begin
				state_d = divider_pkg::ST_IDLE;
			end
		endcase
		// Capture results after the eighth iteration
		if (state_q == divider_pkg::ST_RUN && iter_q == `DIV_ITERS - `DIV_CNT_W'(1))
		begin
			res_d.quotient  = quo_d;
			res_d.remainder = rem_d;
		end
	end

	// Remainder in multiply mode starts as the dividend itself
	// (zero quotient), so a run that rejects every trial still leaves N - D*Q.
	// The start branch above loads it that way.

	//------------------------------------------------------------------
	// Registers
	//------------------------------------------------------------------

	// Register all state, frozen while the enable is low
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state_q <= divider_pkg::ST_IDLE;
			iter_q  <= '0;
			mode_q  <= `DIV_MODE_SUB;
			num_q   <= `DIV_ZERO_BYTE;
			den_q   <= `DIV_ZERO_BYTE;
			quo_q   <= `DIV_ZERO_BYTE;
			rem_q   <= `DIV_ZERO_BYTE;
			res_q   <= '0;
		end
		else if (i_ce)
		begin
			state_q <= state_d;
			iter_q  <= iter_d;
			mode_q  <= mode_d;
			num_q   <= num_d;
			den_q   <= den_d;
			quo_q   <= quo_d;
			rem_q   <= rem_d;
			res_q   <= res_d;
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------

	// Handshake outputs and registered result
	assign o_busy   = (state_q == divider_pkg::ST_RUN);
	assign o_done   = (state_q == divider_pkg::ST_DONE);
	assign o_result = res_q;

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------

	logic [`DIV_WIDTH-1:0] exp_q, exp_r;
	logic [2*`DIV_WIDTH-1:0] chk_prod;
	always_comb
	begin
		exp_q    = (den_q == `DIV_ZERO_BYTE) ? `DIV_ZERO_BYTE : num_q / den_q;
		exp_r    = (den_q == `DIV_ZERO_BYTE) ? `DIV_ZERO_BYTE : num_q % den_q;
		chk_prod = res_q.quotient * den_q;
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	start_to_done_a: assert property (i_ce && i_start && !o_busy ##1 i_ce[*8] |=> o_done)
		else $error("done not eight cycles after start");
	done_one_cycle_a: assert property (o_done && i_ce |=> !o_done)
		else $error("done held longer than one cycle");
	quotient_value_a: assert property (o_done && den_q != `DIV_ZERO_BYTE && num_q > den_q
		|-> o_result.quotient == exp_q)
		else $error("quotient wrong");
	remainder_sub_a: assert property (o_done && mode_q == `DIV_MODE_SUB && den_q != `DIV_ZERO_BYTE
		&& num_q > den_q |-> o_result.remainder == exp_r)
		else $error("subtraction remainder wrong");
	remainder_mul_a: assert property (o_done && mode_q == `DIV_MODE_MUL && den_q != `DIV_ZERO_BYTE
		&& num_q > den_q |-> o_result.remainder == num_q - chk_prod[`DIV_WIDTH-1:0])
		else $error("multiplication remainder wrong");
	rem_cleared_a: assert property (i_ce && i_start && !o_busy && i_mode == `DIV_MODE_SUB
		|=> rem_q == `DIV_ZERO_BYTE)
		else $error("remainder not cleared at start");
	trial_onehot_a: assert property (o_busy |-> $onehot(trial_bit) && (trial_q & ~keep_mask) == trial_bit)
		else $error("trial quotient malformed");
	exact_zero_a: assert property (o_busy && i_ce && mode_q == `DIV_MODE_SUB && sub_diff == '0
		|=> rem_q == `DIV_ZERO_BYTE && (quo_q & $past(trial_bit)) != '0)
		else $error("zero difference not accepted");
	shift_fill_a: assert property (o_busy && i_ce && mode_q == `DIV_MODE_SUB && sub_neg
		|=> rem_q == $past(shifted[`DIV_WIDTH-1:0]))
		else $error("shift fill wrong");

	run_sub_c: cover property (o_done && mode_q == `DIV_MODE_SUB);
	run_mul_c: cover property (o_done && mode_q == `DIV_MODE_MUL);
	stall_c:   cover property (o_busy && !i_ce);
	zero_rem_c: cover property (o_done && o_result.remainder == `DIV_ZERO_BYTE);
	back_to_back_c: cover property (o_done && i_ce && i_start);

endmodule

`default_nettype wire

//--- rtl/mul_add_slice.sv
// Combinational multiply-add slice: p = c - a*b, with sign of the result
// Assumes unsigned 8-bit operands; purely combinational, no pipeline stages
`timescale 1ns/1ps
`default_nettype none
`include "divider_defs.svh"

module mul_add_slice
(
	// Operands
	input  wire logic [`DIV_WIDTH-1:0]   i_a,
	input  wire logic [`DIV_WIDTH-1:0]   i_b,
	input  wire logic [`DIV_WIDTH-1:0]   i_c,
	// Result
	output logic      [2*`DIV_WIDTH:0]   o_p,
	output logic                         o_neg
);

	logic [2*`DIV_WIDTH-1:0] prod;

	// Product and difference, one guard bit for the sign
	always_comb
	begin
		prod  = i_a * i_b;
		o_p   = {1'b0, `DIV_ZERO_BYTE, i_c} - {1'b0, prod};
		o_neg = o_p[2*`DIV_WIDTH];
	end

endmodule

`default_nettype wire
